// file: rtl/tap_pkg.sv
// Shared constants and types of the test access port
package tap_pkg;

    // ************************************************
    // Register widths
    // ************************************************
    localparam int IR_W  = 3;
    localparam int ID_W  = 32;
    localparam int BSR_W = 70;

    // ************************************************
    // Instruction codes
    // ************************************************
    localparam logic [IR_W-1:0] IR_BYPASS0  = 3'h0;
    localparam logic [IR_W-1:0] IR_IDENT    = 3'h1;
    localparam logic [IR_W-1:0] IR_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] IR_BYPASS3  = 3'h3;
    localparam logic [IR_W-1:0] IR_SAMPLE   = 3'h4;
    localparam logic [IR_W-1:0] IR_RESERVED = 3'h5;
    localparam logic [IR_W-1:0] IR_BYPASS6  = 3'h6;
    localparam logic [IR_W-1:0] IR_BYPASS7  = 3'h7;

    // ************************************************
    // Values after reset and capture values
    // ************************************************
    localparam logic [IR_W-1:0] IR_RESET_VAL = IR_IDENT;
    localparam logic            BYP_CAPTURE  = 1'b0;
    localparam logic            ID_START_BIT = 1'b1;
    localparam logic [2:0]      TLR_TMS_COUNT = 3'h5;

    // ************************************************
    // Controller states
    // ************************************************
    typedef enum logic [15:0] {
        ST_TLR   = 16'h0001,
        ST_RTI   = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR  = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PSDR  = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDR  = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR  = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PSIR  = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPIR  = 16'h8000
    } tap_state_t;

endpackage

// file: rtl/tap_ctl_if.sv
// Carrier between the port datapath and its state controller
interface tap_ctl_if;
    logic                tck_rise;
    logic                tms;
    tap_pkg::tap_state_t state;

    modport ctl (input tck_rise, input tms, output state);
    modport dp  (output tck_rise, output tms, input state);
endinterface

// file: rtl/tap_fsm.sv
// Sixteen-state test-port controller
module tap_fsm (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Datapath side
    tap_ctl_if.ctl    ctl
);

    tap_pkg::tap_state_t state_ff;
    tap_pkg::tap_state_t nxt_state;

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            tap_pkg::ST_TLR:   nxt_state = ctl.tms ? tap_pkg::ST_TLR   : tap_pkg::ST_RTI;
            tap_pkg::ST_RTI:   nxt_state = ctl.tms ? tap_pkg::ST_SELDR : tap_pkg::ST_RTI;
            tap_pkg::ST_SELDR: nxt_state = ctl.tms ? tap_pkg::ST_SELIR : tap_pkg::ST_CAPDR;
            tap_pkg::ST_CAPDR: nxt_state = ctl.tms ? tap_pkg::ST_EX1DR : tap_pkg::ST_SHDR;
            tap_pkg::ST_SHDR:  nxt_state = ctl.tms ? tap_pkg::ST_EX1DR : tap_pkg::ST_SHDR;
            tap_pkg::ST_EX1DR: nxt_state = ctl.tms ? tap_pkg::ST_UPDR  : tap_pkg::ST_PSDR;
            tap_pkg::ST_PSDR:  nxt_state = ctl.tms ? tap_pkg::ST_EX2DR : tap_pkg::ST_PSDR;
            tap_pkg::ST_EX2DR: nxt_state = ctl.tms ? tap_pkg::ST_UPDR  : tap_pkg::ST_SHDR;
            tap_pkg::ST_UPDR:  nxt_state = ctl.tms ? tap_pkg::ST_SELDR : tap_pkg::ST_RTI;
            tap_pkg::ST_SELIR: nxt_state = ctl.tms ? tap_pkg::ST_TLR   : tap_pkg::ST_CAPIR;
            tap_pkg::ST_CAPIR: nxt_state = ctl.tms ? tap_pkg::ST_EX1IR : tap_pkg::ST_SHIR;
            tap_pkg::ST_SHIR:  nxt_state = ctl.tms ? tap_pkg::ST_EX1IR : tap_pkg::ST_SHIR;
            tap_pkg::ST_EX1IR: nxt_state = ctl.tms ? tap_pkg::ST_UPIR  : tap_pkg::ST_PSIR;
            tap_pkg::ST_PSIR:  nxt_state = ctl.tms ? tap_pkg::ST_EX2IR : tap_pkg::ST_PSIR;
            tap_pkg::ST_EX2IR: nxt_state = ctl.tms ? tap_pkg::ST_UPIR  : tap_pkg::ST_SHIR;
            tap_pkg::ST_UPIR:  nxt_state = ctl.tms ? tap_pkg::ST_SELDR : tap_pkg::ST_RTI;
            default:           nxt_state = tap_pkg::ST_TLR;
        endcase
    end

    // Only a test clock rising edge moves the controller
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= tap_pkg::ST_TLR;
        end else if (ctl.tck_rise) begin // [RQ1]
            state_ff <= nxt_state; // [RQ12]
        end
    end

    assign ctl.state = state_ff;

    // ************************************************
    // Checks
    // ************************************************
    logic [2:0] tms_run_ff;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tms_run_ff <= 3'h0;
        end else if (ctl.tck_rise) begin
            if (!ctl.tms) begin
                tms_run_ff <= 3'h0;
            end else if (tms_run_ff != tap_pkg::TLR_TMS_COUNT) begin
                tms_run_ff <= tms_run_ff + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    state_hold_a: assert property (!ctl.tck_rise |=> $stable(state_ff)) // [RQ1]
        else $error("controller moved without a test clock edge");
    five_high_a: assert property (tms_run_ff == tap_pkg::TLR_TMS_COUNT |-> state_ff == tap_pkg::ST_TLR) // [RQ12]
        else $error("five high mode-select samples did not reach logic reset");
    tms_steer_a: assert property (ctl.tck_rise && state_ff == tap_pkg::ST_SELDR
                                  |=> state_ff == (ctl.tms ? tap_pkg::ST_SELIR : tap_pkg::ST_CAPDR)) // [RQ2]
        else $error("mode-select did not steer the controller");

endmodule

// file: rtl/sram_boundary_scan_tap.sv
// Test access port with instruction, identification, bypass and boundary-scan registers
//
// Function
// [RQ1] Controller changes state only on test clock transitions.
// [RQ2] Mode-select sampled at each test clock rise and steers the controller.
// [RQ3] Data-in sampled at each test clock rise into the selected register.
// [RQ4] Data-out updated from the selected register at each test clock fall.
// [RQ5] One controller, one instruction register, identification, bypass and boundary-scan registers.
// [RQ6] Memory operation untouched except while sample-with-outputs-off is active.
// [RQ7] Unused port: system holds test clock low, mode-select and data-in high.
// [RQ8] 3-bit decode: bypass, identification, sample-z, sample, reserved.
// [RQ9] Identification instruction loaded at reset and capture; new one acts at update.
// [RQ10] 32-bit identification register, bit 0 fixed one, shifts toward bit 0.
// [RQ11] One-bit bypass register loads zero at capture while bypass active.
// [RQ12] Standard sixteen-state controller; five high mode-select samples reset it.
module sram_boundary_scan_tap #(
    parameter int                        BSR_W    = tap_pkg::BSR_W,
    // Arbitrary identification value; bit 0 is forced to one on capture
    parameter logic [tap_pkg::ID_W-1:0]  ID_VALUE = 32'h0A5C_3E91
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // Test port pins
    input  wire logic             tck_i,
    input  wire logic             tms_i,
    input  wire logic             tdi_i,
    output logic                  tdo_o,
    output logic                  tdo_oe_o,
    // Memory I/O ring
    input  wire logic [BSR_W-1:0] ring_i,
    output logic                  dq_off_o
);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic tck_meta_ff;
    logic tck_sync_ff;
    logic tck_prev_ff;
    logic tms_meta_ff;
    logic tms_sync_ff;
    logic tdi_meta_ff;
    logic tdi_sync_ff;
    logic tck_rise;
    logic tck_fall;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tck_meta_ff <= 1'b0;
            tck_sync_ff <= 1'b0;
            tck_prev_ff <= 1'b0;
            tms_meta_ff <= 1'b1;
            tms_sync_ff <= 1'b1;
            tdi_meta_ff <= 1'b1;
            tdi_sync_ff <= 1'b1;
        end else begin
            tck_meta_ff <= tck_i;
            tck_sync_ff <= tck_meta_ff;
            tck_prev_ff <= tck_sync_ff;
            tms_meta_ff <= tms_i;
            tms_sync_ff <= tms_meta_ff;
            tdi_meta_ff <= tdi_i;
            tdi_sync_ff <= tdi_meta_ff;
        end
    end

    // Mode-select and data-in share the clock's latency, so they are aligned with the edge
    assign tck_rise = tck_sync_ff & ~tck_prev_ff;
    assign tck_fall = ~tck_sync_ff & tck_prev_ff;

    // ************************************************
    // Controller
    // ************************************************
    tap_ctl_if ctl_if ();

    assign ctl_if.tck_rise = tck_rise;
    assign ctl_if.tms      = tms_sync_ff; // [RQ2]

    tap_fsm u_fsm (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ctl      (ctl_if.ctl)
    );

    tap_pkg::tap_state_t state;
    assign state = ctl_if.state;

    // ************************************************
    // Instruction register
    // ************************************************
    logic [tap_pkg::IR_W-1:0] ir_shift_ff;
    logic [tap_pkg::IR_W-1:0] ir_ff;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_shift_ff <= tap_pkg::IR_RESET_VAL;
        end else if (tck_rise) begin
            if (state == tap_pkg::ST_CAPIR || state == tap_pkg::ST_TLR) begin
                ir_shift_ff <= tap_pkg::IR_RESET_VAL; // [RQ9]
            end else if (state == tap_pkg::ST_SHIR) begin
                ir_shift_ff <= {tdi_sync_ff, ir_shift_ff[tap_pkg::IR_W-1:1]}; // [RQ3]
            end
        end
    end

    // Active instruction changes only in logic reset or at the update fall
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_ff <= tap_pkg::IR_RESET_VAL;
        end else if (state == tap_pkg::ST_TLR) begin
            ir_ff <= tap_pkg::IR_RESET_VAL; // [RQ9]
        end else if (tck_fall && state == tap_pkg::ST_UPIR) begin
            ir_ff <= ir_shift_ff; // [RQ9]
        end
    end

    // ************************************************
    // Instruction decode
    // ************************************************
    logic sel_id;
    logic sel_bsr;
    logic sel_byp;

    // Reserved code falls back to the bypass path so the chain length stays defined
    always_comb begin
        sel_id  = 1'b0;
        sel_bsr = 1'b0;
        sel_byp = 1'b0;
        case (ir_ff)
            tap_pkg::IR_IDENT:    sel_id  = 1'b1; // [RQ8]
            tap_pkg::IR_SAMPLE_Z: sel_bsr = 1'b1; // [RQ8]
            tap_pkg::IR_SAMPLE:   sel_bsr = 1'b1; // [RQ8]
            default:              sel_byp = 1'b1; // [RQ8]
        endcase
    end

    // ************************************************
    // Data registers
    // ************************************************
    logic [tap_pkg::ID_W-1:0] id_ff;
    logic                     byp_ff;
    logic [BSR_W-1:0]         bsr_ff;
    logic                     cap_dr;
    logic                     sh_dr;

    assign cap_dr = tck_rise && state == tap_pkg::ST_CAPDR;
    assign sh_dr  = tck_rise && state == tap_pkg::ST_SHDR;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            id_ff <= '0;
        end else if (sel_id && cap_dr) begin
            id_ff <= {ID_VALUE[tap_pkg::ID_W-1:1], tap_pkg::ID_START_BIT}; // [RQ10]
        end else if (sel_id && sh_dr) begin
            id_ff <= {tdi_sync_ff, id_ff[tap_pkg::ID_W-1:1]}; // [RQ10]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            byp_ff <= tap_pkg::BYP_CAPTURE;
        end else if (sel_byp && cap_dr) begin
            byp_ff <= tap_pkg::BYP_CAPTURE; // [RQ11]
        end else if (sel_byp && sh_dr) begin
            byp_ff <= tdi_sync_ff; // [RQ11]
        end
    end

    // Sample-only chain: no update stage, so scanning never drives the ring
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bsr_ff <= '0;
        end else if (sel_bsr && cap_dr) begin
            bsr_ff <= ring_i; // [RQ5]
        end else if (sel_bsr && sh_dr) begin
            bsr_ff <= {tdi_sync_ff, bsr_ff[BSR_W-1:1]}; // [RQ3]
        end
    end

    // ************************************************
    // Serial output and output disable
    // ************************************************
    logic tdo_ff;
    logic tdo_oe_ff;
    logic dq_off_ff;
    logic tdo_nxt;

    always_comb begin
        if (state == tap_pkg::ST_SHIR) begin
            tdo_nxt = ir_shift_ff[0];
        end else if (sel_id) begin
            tdo_nxt = id_ff[0];
        end else if (sel_bsr) begin
            tdo_nxt = bsr_ff[0];
        end else begin
            tdo_nxt = byp_ff;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff    <= tdo_nxt; // [RQ4]
            tdo_oe_ff <= state == tap_pkg::ST_SHIR || state == tap_pkg::ST_SHDR; // [RQ4]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dq_off_ff <= 1'b0;
        end else begin
            dq_off_ff <= ir_ff == tap_pkg::IR_SAMPLE_Z; // [RQ6]
        end
    end

    assign tdo_o    = tdo_ff;
    assign tdo_oe_o = tdo_oe_ff;
    assign dq_off_o = dq_off_ff;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    ir_reset_a: assert property (state == tap_pkg::ST_TLR |=> ir_ff == tap_pkg::IR_IDENT) // [RQ9]
        else $error("instruction not reset to identification");
    ir_hold_a: assert property (state != tap_pkg::ST_TLR && !(tck_fall && state == tap_pkg::ST_UPIR)
                                |=> $stable(ir_ff)) // [RQ9]
        else $error("instruction changed outside update");
    tdo_fall_a: assert property (!tck_fall |=> $stable(tdo_ff) && $stable(tdo_oe_ff)) // [RQ4]
        else $error("data-out changed without a falling test clock");
    byp_cap_a: assert property (sel_byp && cap_dr |=> byp_ff == 1'b0) // [RQ11]
        else $error("bypass did not capture zero");
    id_cap_a: assert property (sel_id && cap_dr |=> id_ff[0] == 1'b1 && id_ff[31:1] == ID_VALUE[31:1]) // [RQ10]
        else $error("identification capture wrong");
    id_shift_a: assert property (sel_id && sh_dr |=> id_ff[31] == $past(tdi_sync_ff)
                                 && id_ff[30:0] == $past(id_ff[31:1])) // [RQ3]
        else $error("identification shift wrong");
    decode_one_a: assert property ($onehot({sel_id, sel_bsr, sel_byp})
                                   && (sel_bsr == (ir_ff == 3'h2 || ir_ff == 3'h4))) // [RQ8]
        else $error("instruction decode not exclusive");
    dq_off_a: assert property (##1 dq_off_o == ($past(ir_ff) == tap_pkg::IR_SAMPLE_Z)) // [RQ6]
        else $error("output disable does not follow sample-z");
    bsr_cap_a: assert property (sel_bsr && cap_dr |=> bsr_ff == $past(ring_i)) // [RQ5]
        else $error("boundary scan capture wrong");

endmodule

// file: test/scan_master.sv
// Behavioural scan master that drives the test port pins
module scan_master (
    // Clock
    input  wire logic clk_i,
    // Test port pins
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************
    // Pin driving
    // ************************************************
    // Unused port: clock parked low, mode and data lines pulled high
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // One 80 ns test clock period; tdo is read late in the high phase,
    // where it still holds the value launched at the previous fall
    task automatic clock_bit(input logic tms, input logic tdi, output logic tdo, output logic oe);
        @(posedge clk_i);
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (3) @(posedge clk_i);
        tck_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        tdo = tdo_i;
        oe  = tdo_oe_i;
        tck_o <= 1'b0;
        // Hold time is over: show the opposite level so stale bits cannot pass
        tms_o <= ~tms;
        tdi_o <= ~tdi;
    endtask

    // Toggle mode and data lines while the test clock stands still
    task automatic wiggle();
        repeat (16) begin
            @(posedge clk_i);
            tms_o <= ~tms_o;
            tdi_o <= ~tdi_o;
        end
    endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench of the SRAM test access port
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************
    // Setup
    // ************************************************
    localparam int            BW     = tap_pkg::BSR_W;
    // Arbitrary identification value; bit 0 left low to see it forced
    localparam logic [31:0]   ID_VAL = 32'h6B2D_4C10;
    localparam logic [BW-1:0] RING_A = {6'h2A, 64'hF0E1_D2C3_B4A5_9687};

    logic          clk_i      = 1'b0;
    logic          arst_n_i   = 1'b0;
    logic          tck;
    logic          tms;
    logic          tdi;
    logic          tdo;
    logic          tdo_oe;
    logic          dq_off;
    logic [BW-1:0] ring_i     = '0;
    logic          q_s;
    logic          oe_s;
    logic [79:0]   dout;
    int            mismatches = 0;
    int            num_checks = 0;

    always #5 clk_i = ~clk_i;

    sram_boundary_scan_tap #(.BSR_W(BW), .ID_VALUE(ID_VAL)) sram_boundary_scan_tap_inst (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .tck_i    (tck),
        .tms_i    (tms),
        .tdi_i    (tdi),
        .tdo_o    (tdo),
        .tdo_oe_o (tdo_oe),
        .ring_i   (ring_i),
        .dq_off_o (dq_off)
    );

    scan_master scan_master_inst (
        .clk_i    (clk_i),
        .tck_o    (tck),
        .tms_o    (tms),
        .tdi_o    (tdi),
        .tdo_i    (tdo),
        .tdo_oe_i (tdo_oe)
    );

    // ************************************************
    // Tasks
    // ************************************************
    task automatic check(input logic [79:0] got, input logic [79:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic step(input logic m, input logic d);
        scan_master_inst.clock_bit(m, d, q_s, oe_s);
    endtask

    // From idle: select, capture, shift n bits, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [79:0] din);
        dout = '0;
        step(1'b1, 1'b1);
        if (ir) begin
            step(1'b1, 1'b1);
        end
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = q_s;
            check(oe_s, 1'b1, "enable in shift");
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        check(oe_s, 1'b0, "enable after shift");
    endtask

    task automatic load_ir(input logic [2:0] code);
        scan(1'b1, 3, {77'h0, code});
        check(dout, 80'h1, "instruction capture");
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic test_ident();
        step(1'b0, 1'b1);
        scan_master_inst.wiggle();
        check(dq_off, 1'b0, "outputs on after reset");
        scan(1'b0, 34, 80'h2);
        check(dout, {46'h0, 2'b10, ID_VAL[31:1], 1'b1}, "identification scan");
        $display("Test identification done");
    endtask

    task automatic test_bypass();
        logic [2:0] codes [5] = '{tap_pkg::IR_BYPASS0, tap_pkg::IR_BYPASS3, tap_pkg::IR_BYPASS6,
                                  tap_pkg::IR_BYPASS7, tap_pkg::IR_RESERVED};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            scan(1'b0, 4, 80'hD);
            check(dout, 80'hA, "bypass path");
            check(dq_off, 1'b0, "outputs on in bypass");
        end
        $display("Test bypass done");
    endtask

    task automatic test_sample();
        ring_i <= RING_A;
        load_ir(tap_pkg::IR_SAMPLE);
        check(dq_off, 1'b0, "outputs on in sample");
        scan(1'b0, BW + 1, '0);
        check(dout, {10'h0, RING_A}, "sample capture");
        ring_i <= ~RING_A;
        load_ir(tap_pkg::IR_SAMPLE_Z);
        check(dq_off, 1'b1, "outputs off in sample-z");
        scan(1'b0, BW, '0);
        check(dout, {10'h0, ~RING_A}, "sample-z capture");
        $display("Test sample done");
    endtask

    // Five high samples from the shift state are the longest way to reset
    task automatic test_tms_reset();
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        repeat (4) step(1'b1, 1'b1);
        check(dq_off, 1'b1, "four high samples");
        repeat (2) step(1'b1, 1'b1);
        check(dq_off, 1'b0, "five high samples");
        step(1'b0, 1'b1);
        scan(1'b0, 32, '0);
        check(dout, {48'h0, ID_VAL[31:1], 1'b1}, "identification after reset");
        $display("Test mode-select reset done");
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        test_ident();
        test_bypass();
        test_sample();
        test_tms_reset();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        complete_run();
    end
endmodule
